//--- logic/relay_bank_regs.svh
// constants for the relay output bank: offsets, fields, resets, timing
// assumes byte offsets relative to the jumpered base, 250 MHz ref_clk
`ifndef RELAY_BANK_REGS_SVH
`define RELAY_BANK_REGS_SVH

`define OFS_IDENTITY_HI 5'h00
`define OFS_IDENTITY_LO 5'h01
`define OFS_CONTROL_HI 5'h02
`define OFS_CONTROL_LO 5'h03
`define OFS_OUTPUT_BASE 5'h10
`define OFS_CONTACT_BASE 5'h18

`define CTL_FAIL_LED_OFF_BIT 15
`define CTL_LOWER_ENABLE_BIT 14
`define CTL_UPPER_ENABLE_BIT 13
`define CTL_RESET_VALUE 16'h0000
`define OUTPUT_RESET_VALUE 64'h0000_0000_0000_0000

`define AM_SPACE_SHORT 3'h5
`define AM_SPACE_STANDARD 3'h7

`define CLK_PERIOD_NS 4
`define ACK_DELAY_NS 150

`endif

//--- logic/relay_bank_pkg.sv
// types shared by the relay output bank
// assumes nothing beyond the single ref_clk domain
`default_nettype none
package relay_bank_pkg;

  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_DELAY = 2'b01,
    CYC_ACK = 2'b10
  } cycle_state_t;

endpackage
`default_nettype wire

//--- logic/coil_driver_half.sv
// one half of the relay bank: complementary set/reset coil drivers
// assumes out_bits come from the output registers of the parent
`timescale 1ns/100ps
`default_nettype none
module coil_driver_half #(
  parameter int WIDTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] out_bits,
  input wire logic enable,
  output logic [WIDTH-1:0] set_drive_q,
  output logic [WIDTH-1:0] reset_drive_q,
  output logic drive_oe_q
);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      set_drive_q <= '0;
      reset_drive_q <= '0;
      drive_oe_q <= 1'b0;
    end else begin
      set_drive_q <= out_bits;
      reset_drive_q <= ~out_bits;
      drive_oe_q <= enable;
    end
  end

endmodule
`default_nettype wire

//--- logic/relay_output_bank.sv
// relay output bank: backplane slave, control word, output and contact registers
// assumes backplane inputs synchronous to ref_clk and jumpers static
`timescale 1ns/100ps
`default_nettype none
`include "relay_bank_regs.svh"
module relay_output_bank
  import relay_bank_pkg::*;
#(
  parameter logic [7:0] BOARD_CODE = 8'hA5, // arbitrary value
  parameter int CHANNELS = 64
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [23:1] addr,
  input wire logic [5:0] am,
  input wire logic as_n,
  input wire logic ds0_n,
  input wire logic ds1_n,
  input wire logic lword_n,
  input wire logic write_n,
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic data_oe,
  output logic dtack_n,
  input wire logic address_space_select_jumper,
  input wire logic nonprivileged_only_jumper,
  input wire logic either_privilege_jumper,
  input wire logic [23:5] base_address_jumpers,
  input wire logic [CHANNELS-1:0] contact_state,
  output logic fail_led_on,
  output logic [CHANNELS/2-1:0] lower_set_drive,
  output logic [CHANNELS/2-1:0] lower_reset_drive,
  output logic lower_drive_oe,
  output logic [CHANNELS/2-1:0] upper_set_drive,
  output logic [CHANNELS/2-1:0] upper_reset_drive,
  output logic upper_drive_oe,
  output logic board_selected
);

  // ****************************************
  // timing
  // ****************************************
  localparam int ACK_CYCLES = (`ACK_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [5:0] ACK_LAST = 6'(ACK_CYCLES - 1);

  // ****************************************
  // state
  // ****************************************
  cycle_state_t state_q, state_d;
  logic [5:0] delay_q;
  logic [4:0] cyc_ofs_q;
  logic cyc_lword_q;
  logic cyc_ds0_q;
  logic cyc_ds1_q;
  logic cyc_write_q;
  logic [31:0] cyc_data_q;
  logic [15:0] control_q;
  logic [CHANNELS-1:0] output_q;
  logic [31:0] data_out_q;
  logic data_oe_q;
  logic dtack_n_q;
  logic fail_led_on_q;
  logic board_selected_q;

  // ****************************************
  // board select decode
  // ****************************************
  // jumper picks standard or short space
  wire logic standard_space = address_space_select_jumper;
  wire logic [2:0] am_space = am[5:3];
  wire logic am_kind_ok = standard_space ? (am[1:0] == 2'b01 || am[1:0] == 2'b10)
                                         : (am[1:0] == 2'b01);
  wire logic space_hit = am_kind_ok &&
                         (am_space == (standard_space ? `AM_SPACE_STANDARD : `AM_SPACE_SHORT));
  wire logic supervisory_cycle = am[2];
  wire logic privilege_hit = nonprivileged_only_jumper ? !supervisory_cycle :
                             either_privilege_jumper ? 1'b1 : supervisory_cycle;
  // installed jumper means line must be zero
  wire logic [23:5] base_expect = ~base_address_jumpers;
  wire logic low_addr_hit = (addr[15:5] == base_expect[15:5]);
  wire logic high_addr_hit = !standard_space || (addr[23:16] == base_expect[23:16]);
  wire logic strobe_low = !ds0_n || !ds1_n;
  wire logic strobes_high = ds0_n && ds1_n;
  wire logic select_now = !as_n && strobe_low && space_hit && privilege_hit &&
                          low_addr_hit && high_addr_hit;
  wire logic [4:0] byte_ofs_now = {addr[4:1], !lword_n ? 1'b0 : ds1_n};

  // ****************************************
  // byte lane steering
  // ****************************************
  // slot i carries data byte [31-8i -: 8]
  // longword uses all four slots, else slots 2 and 3
  logic [4:0] slot_ofs [4];
  logic [3:0] slot_en;
  wire logic long_ok = cyc_lword_q && !cyc_ofs_q[1] && cyc_ds0_q && cyc_ds1_q;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_slot
      if (gi < 2) begin : g_hi
        assign slot_ofs[gi] = {cyc_ofs_q[4:2], 2'(gi)};
        assign slot_en[gi] = long_ok;
      end else begin : g_lo
        assign slot_ofs[gi] = cyc_lword_q ? {cyc_ofs_q[4:2], 2'(gi)}
                                          : {cyc_ofs_q[4:1], 1'(gi - 2)};
        assign slot_en[gi] = cyc_lword_q ? long_ok : (gi == 2 ? cyc_ds1_q : cyc_ds0_q);
      end
    end
  endgenerate

  // ****************************************
  // register read mux
  // ****************************************
  function automatic logic [7:0] read_byte(
    input logic [4:0] ofs,
    input logic [15:0] ctl,
    input logic [CHANNELS-1:0] outs,
    input logic [CHANNELS-1:0] contacts
  );
    logic [7:0] val;
    val = 8'h00;
    if (ofs == `OFS_IDENTITY_HI) begin
      // fixed code, lower byte left at zero
      val = BOARD_CODE;
    end else if (ofs == `OFS_CONTROL_HI) begin
      val = ctl[15:8];
    end else if (ofs == `OFS_CONTROL_LO) begin
      val = ctl[7:0];
    end else if (ofs[4:3] == `OFS_OUTPUT_BASE >> 3) begin
      val = outs[(7 - ofs[2:0]) * 8 +: 8];
    end else if (ofs[4:3] == `OFS_CONTACT_BASE >> 3) begin
      val = contacts[(7 - ofs[2:0]) * 8 +: 8];
    end
    return val;
  endfunction

  // only 64-channel builds fill every byte; narrower builds read X in the bytes past CHANNELS
  logic [63:0] outs_wide;
  logic [63:0] contacts_wide;
  assign outs_wide = 64'(output_q);
  assign contacts_wide = 64'(contact_state);

  logic [31:0] read_word;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_rd
      assign read_word[(3 - gi) * 8 +: 8] =
        slot_en[gi] ? read_byte(slot_ofs[gi], control_q, outs_wide[CHANNELS-1:0],
                                contacts_wide[CHANNELS-1:0]) : 8'h00;
    end
  endgenerate

  // ****************************************
  // cycle sequencer
  // ****************************************
  wire logic delay_done = (delay_q == ACK_LAST);
  wire logic commit = (state_q == CYC_DELAY) && delay_done;

  always_comb begin
    state_d = state_q;
    case (state_q)
      CYC_IDLE: begin
        if (select_now) begin
          state_d = CYC_DELAY;
        end
      end
      CYC_DELAY: begin
        if (delay_done) begin
          state_d = CYC_ACK;
        end
      end
      CYC_ACK: begin
        // re-arm once host lets go of the strobes
        if (strobes_high) begin
          state_d = CYC_IDLE;
        end
      end
      default: begin
        state_d = CYC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= CYC_IDLE;
      delay_q <= 6'h00;
    end else begin
      state_q <= state_d;
      delay_q <= (state_q == CYC_DELAY) ? delay_q + 6'h01 : 6'h00;
    end
  end

  // cycle is latched at select so the host may move on early
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cyc_ofs_q <= 5'h00;
      cyc_lword_q <= 1'b0;
      cyc_ds0_q <= 1'b0;
      cyc_ds1_q <= 1'b0;
      cyc_write_q <= 1'b0;
      cyc_data_q <= 32'h0000_0000;
    end else if (state_q == CYC_IDLE && select_now) begin
      cyc_ofs_q <= byte_ofs_now;
      cyc_lword_q <= !lword_n;
      cyc_ds0_q <= !ds0_n;
      cyc_ds1_q <= !ds1_n;
      cyc_write_q <= !write_n;
      cyc_data_q <= data_in;
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  // control cleared at reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      control_q <= `CTL_RESET_VALUE;
      output_q <= CHANNELS'(`OUTPUT_RESET_VALUE);
    end else if (commit && cyc_write_q) begin
      for (int i = 0; i < 4; i++) begin
        if (slot_en[i]) begin
          // identity and contact writes fall through unstored
          // whole word stored, only top bits used
          if (slot_ofs[i] == `OFS_CONTROL_HI) begin
            control_q[15:8] <= cyc_data_q[(3 - i) * 8 +: 8];
          end
          if (slot_ofs[i] == `OFS_CONTROL_LO) begin
            control_q[7:0] <= cyc_data_q[(3 - i) * 8 +: 8];
          end
          if (slot_ofs[i][4:3] == `OFS_OUTPUT_BASE >> 3 &&
              (7 - slot_ofs[i][2:0]) * 8 < CHANNELS) begin
            output_q[(7 - slot_ofs[i][2:0]) * 8 +: 8] <= cyc_data_q[(3 - i) * 8 +: 8];
          end
        end
      end
    end
  end

  // ****************************************
  // bus answer
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_out_q <= 32'h0000_0000;
      data_oe_q <= 1'b0;
      dtack_n_q <= 1'b1;
      board_selected_q <= 1'b0;
    end else begin
      board_selected_q <= (state_d != CYC_IDLE);
      if (commit) begin
        dtack_n_q <= 1'b0;
        data_out_q <= cyc_write_q ? 32'h0000_0000 : read_word;
        data_oe_q <= !cyc_write_q;
      end else if (state_q == CYC_ACK && strobes_high) begin
        // read data held until both strobes high
        dtack_n_q <= 1'b1;
        data_oe_q <= 1'b0;
        data_out_q <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // front panel and coil drivers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fail_led_on_q <= 1'b1;
    end else begin
      fail_led_on_q <= !control_q[`CTL_FAIL_LED_OFF_BIT];
    end
  end

  // bit 14 lower half, bit 13 upper half
  coil_driver_half #(
    .WIDTH(CHANNELS / 2)
  ) u_lower (
    .ref_clk(ref_clk),
    .rst(rst),
    .out_bits(output_q[CHANNELS/2-1:0]),
    .enable(control_q[`CTL_LOWER_ENABLE_BIT]),
    .set_drive_q(lower_set_drive),
    .reset_drive_q(lower_reset_drive),
    .drive_oe_q(lower_drive_oe)
  );

  coil_driver_half #(
    .WIDTH(CHANNELS / 2)
  ) u_upper (
    .ref_clk(ref_clk),
    .rst(rst),
    .out_bits(output_q[CHANNELS-1:CHANNELS/2]),
    .enable(control_q[`CTL_UPPER_ENABLE_BIT]),
    .set_drive_q(upper_set_drive),
    .reset_drive_q(upper_reset_drive),
    .drive_oe_q(upper_drive_oe)
  );

  assign data_out = data_out_q;
  assign data_oe = data_oe_q;
  assign dtack_n = dtack_n_q;
  assign fail_led_on = fail_led_on_q;
  assign board_selected = board_selected_q;

endmodule
`default_nettype wire

//--- tb/relay_bank_properties.sv
// concurrent checks on the relay bank's backplane handshake and coil outputs
// assumes binding to relay_output_bank, one ref_clk domain
`timescale 1ns/100ps
`default_nettype none
module relay_bank_properties #(
  parameter int CHANNELS = 64
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ds0_n,
  input wire logic ds1_n,
  input wire logic [31:0] data_out,
  input wire logic data_oe,
  input wire logic dtack_n,
  input wire logic fail_led_on,
  input wire logic [CHANNELS/2-1:0] lower_set_drive,
  input wire logic [CHANNELS/2-1:0] lower_reset_drive,
  input wire logic lower_drive_oe,
  input wire logic [CHANNELS/2-1:0] upper_set_drive,
  input wire logic [CHANNELS/2-1:0] upper_reset_drive,
  input wire logic upper_drive_oe,
  input wire logic board_selected
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // cycles since select rose; saturates so long holds never wrap
  logic [5:0] sel_age_q;
  always_ff @(posedge ref_clk) begin
    if (rst || !board_selected) begin
      sel_age_q <= 6'h00;
    end else if (sel_age_q != 6'h3F) begin
      sel_age_q <= sel_age_q + 6'h01;
    end
  end
  chk_ack_not_before: assert property (
    board_selected && sel_age_q < 6'h26 |-> dtack_n) else $error("ack before delay");
  chk_reset_leaves_quiet: assert property (
    $fell(rst) |-> fail_led_on && !lower_drive_oe && !upper_drive_oe) else $error("reset state");
  chk_no_early_ack: assert property (
    $rose(board_selected) |-> dtack_n [*8]) else $error("ack too early");
  chk_ack_delay: assert property (
    $rose(board_selected) |-> ##[36:40] !dtack_n) else $error("ack too late");
  chk_ack_holds_strobes: assert property (
    !dtack_n && !(ds0_n && ds1_n) |=> !dtack_n) else $error("ack dropped");
  chk_ack_release: assert property (
    !dtack_n && ds0_n && ds1_n |-> ##[1:2] dtack_n) else $error("ack stuck");
  chk_read_drive_ack: assert property (
    data_oe |-> !dtack_n) else $error("data without ack");
  chk_idle_bus_zero: assert property (
    !data_oe |-> data_out == '0) else $error("data while idle");
  chk_lower_coils_apart: assert property (
    lower_drive_oe |-> lower_reset_drive == ~lower_set_drive) else $error("lower coils");
  chk_upper_coils_apart: assert property (
    upper_drive_oe |-> upper_reset_drive == ~upper_set_drive) else $error("upper coils");
  chk_rearm_select: assert property (
    $rose(dtack_n) |-> !board_selected) else $error("select not rearmed");
  cover property ($fell(dtack_n) && !data_oe);
  cover property ($rose(data_oe));
  cover property (lower_drive_oe && upper_drive_oe);
endmodule
`default_nettype wire

//--- tb/host_model.sv
// host CPU model: runs one backplane data cycle per call of cyc()
// assumes one caller at a time and a slave answering with dtack_n
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic ref_clk,
  input wire logic dtack_n,
  input wire logic [31:0] data_out,
  output var logic [23:1] addr,
  output var logic [5:0] am,
  output var logic as_n,
  output var logic ds0_n,
  output var logic ds1_n,
  output var logic lword_n,
  output var logic write_n,
  output var logic [31:0] data_in
);
  // ****************
  // bus cycle
  // ****************
  initial begin
    {as_n, ds0_n, ds1_n, lword_n, write_n} = 5'h1F;
    {addr, am, data_in} = '0;
  end
  task automatic cyc(input logic wr, input logic [5:0] m, input logic [23:1] a,
      input logic [1:0] ds, input logic lw, input logic [31:0] wd,
      output logic [31:0] rd, output logic ack);
    int n;
    @(posedge ref_clk);
    {am, addr, data_in} <= {m, a, wd};
    {write_n, lword_n, as_n} <= {!wr, !lw, 1'b0};
    {ds1_n, ds0_n} <= ~ds;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (dtack_n !== 1'b0 && n < 60);
    ack = (dtack_n === 1'b0);
    rd = data_out;
    {as_n, ds1_n, ds0_n} <= 3'h7;
    // released lines show inverse, not stale data
    {addr, data_in} <= {~a, ~wd};
    repeat (4) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

//--- tb/relay_output_bank_with_selftest_bench.sv
// self-checking bench for the relay bank with a latching relay model
// assumes relays switch at once, so no 7 ms hold is modelled
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) check(64'(g), 64'(e))
module relay_output_bank_with_selftest_bench;
  // ****************
  // bench
  // ****************
  localparam logic [7:0] CODE = 8'h5A; // arbitrary value
  localparam logic [63:0] INIT = 64'h0F0F_3C3C_A5A5_6996;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [23:1] addr;
  logic [5:0] am;
  logic as_n, ds0_n, ds1_n, lword_n, write_n, data_oe, dtack_n, fail_led_on;
  logic [31:0] data_in, data_out, r;
  logic std_j = 1'b0;
  logic np_j = 1'b0;
  logic ep_j = 1'b1;
  logic [63:0] contact_state = INIT;
  logic [31:0] lower_set_drive, lower_reset_drive, upper_set_drive, upper_reset_drive;
  logic lower_drive_oe, upper_drive_oe, k;
  int miscompares = 0;
  int n_tests = 0;
  always #2 ref_clk = ~ref_clk;
  host_model host (.ref_clk, .dtack_n, .data_out, .addr, .am, .as_n, .ds0_n, .ds1_n,
    .lword_n, .write_n, .data_in);
  relay_output_bank #(.BOARD_CODE(CODE), .CHANNELS(64)) dut (.ref_clk, .rst, .addr, .am,
    .as_n, .ds0_n, .ds1_n, .lword_n, .write_n, .data_in, .data_out, .data_oe, .dtack_n,
    .address_space_select_jumper(std_j), .nonprivileged_only_jumper(np_j),
    .either_privilege_jumper(ep_j), .base_address_jumpers(~{8'h00, 11'h52E}),
    .contact_state, .fail_led_on, .lower_set_drive, .lower_reset_drive, .lower_drive_oe,
    .upper_set_drive, .upper_reset_drive, .upper_drive_oe, .board_selected());
  // latching relays move only while their half is driven
  always @(posedge ref_clk) begin
    if (lower_drive_oe) contact_state[31:0] <= lower_set_drive;
    if (upper_drive_oe) contact_state[63:32] <= upper_set_drive;
  end
  function automatic logic [23:1] ad(input logic [4:0] o);
    return {8'h3C, 11'h52E, o[4:1]};
  endfunction
  task automatic check(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] o, input logic [1:0] ds, input logic lw,
      input logic [31:0] d);
    logic [31:0] x;
    host.cyc(1'b1, 6'h29, ad(o), ds, lw, d, x, k);
    `CHK(k, 1'b1);
  endtask
  task automatic rdc(input logic [4:0] o, input logic [1:0] ds, input logic lw,
      input logic [31:0] m, input logic [31:0] e, output logic [31:0] x);
    host.cyc(1'b0, 6'h29, ad(o), ds, lw, 32'h0, x, k);
    `CHK({k, x & m}, {1'b1, e});
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHK({fail_led_on, lower_drive_oe, upper_drive_oe}, 3'b100);
    rdc(5'h02, 2'b11, 1'b0, 32'hFFFF, 32'h0, r);
    rdc(5'h00, 2'b10, 1'b0, 32'hFF00, {16'h0, CODE, 8'h0}, r);
    wr(5'h00, 2'b11, 1'b0, 32'h0);
    rdc(5'h00, 2'b11, 1'b1, 32'hFF00FFFF, {CODE, 24'h0}, r);
    wr(5'h02, 2'b11, 1'b0, 32'h1FFF);
    rdc(5'h03, 2'b01, 1'b0, 32'hFF, 32'hFF, r);
    `CHK({fail_led_on, lower_drive_oe, upper_drive_oe}, 3'b100);
    wr(5'h02, 2'b10, 1'b0, 32'h8000);
    `CHK(fail_led_on, 1'b0);
    wr(5'h10, 2'b11, 1'b1, 32'h1234_5678);
    wr(5'h14, 2'b11, 1'b1, 32'h9ABC_DEF0);
    wr(5'h17, 2'b01, 1'b0, 32'h5A);
    rdc(5'h10, 2'b11, 1'b1, '1, 32'h1234_5678, r);
    rdc(5'h14, 2'b11, 1'b1, '1, 32'h9ABC_DE5A, r);
    rdc(5'h18, 2'b11, 1'b1, '1, INIT[63:32], r);
    wr(5'h10, 2'b11, 1'b1, r);
    rdc(5'h1C, 2'b11, 1'b1, '1, INIT[31:0], r);
    wr(5'h14, 2'b11, 1'b1, r);
    // drivers stay enabled until the mid-run reset, relays latch until then
    wr(5'h02, 2'b11, 1'b0, 32'hE000);
    `CHK({lower_drive_oe, upper_drive_oe, lower_set_drive}, {2'b11, INIT[31:0]});
    `CHK(upper_set_drive, INIT[63:32]);
    wr(5'h14, 2'b11, 1'b1, 32'hC3C3_0F0F);
    rdc(5'h1C, 2'b11, 1'b1, '1, 32'hC3C3_0F0F, r);
    `CHK(lower_reset_drive, 32'h3C3C_F0F0);
    for (int j = 0; j < 8; j++) begin
      {np_j, ep_j} <= j[1:0];
      @(posedge ref_clk);
      host.cyc(1'b0, j[2] ? 6'h2D : 6'h29, ad(5'h00), 2'b10, 1'b0, 32'h0, r, k);
      `CHK(k, j[2] ? !j[1] : (j[1] | j[0]));
    end
    std_j <= 1'b1;
    host.cyc(1'b0, 6'h39, ad(5'h00), 2'b10, 1'b0, 32'h0, r, k);
    `CHK(k, 1'b0);
    host.cyc(1'b0, 6'h39, ad(5'h00) & 23'h007FFF, 2'b10, 1'b0, 32'h0, r, k);
    `CHK(k, 1'b1);
    host.cyc(1'b0, 6'h29, ad(5'h00) & 23'h007FFF, 2'b10, 1'b0, 32'h0, r, k);
    `CHK(k, 1'b0);
    // second reset mid-run: control clears, latched contacts hold
    std_j <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHK({fail_led_on, lower_drive_oe, upper_drive_oe}, 3'b100);
    rdc(5'h02, 2'b11, 1'b0, 32'hFFFF, 32'h0, r);
    rdc(5'h1C, 2'b11, 1'b1, '1, 32'hC3C3_0F0F, r);
    complete_run();
  end
endmodule
bind relay_output_bank relay_bank_properties #(.CHANNELS(CHANNELS)) props (.ref_clk, .rst,
  .ds0_n, .ds1_n, .data_out, .data_oe, .dtack_n, .fail_led_on, .lower_set_drive,
  .lower_reset_drive, .lower_drive_oe, .upper_set_drive, .upper_reset_drive,
  .upper_drive_oe, .board_selected);
`default_nettype wire
